// ===== verilog/fpl_pkg.sv
// Constants, encodings and types shared by the flash programming lock block
package fpl_pkg;
  // Clock and self-timed operation lengths
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_TIME_NS = 50000;
  localparam int ERASE_TIME_MS = 500;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [2:0] CAPTURE_DELAY = 3'h5; // Edges until the filtered access pin is valid
  // Code array
  localparam int ADDR_W = 12;
  localparam int MEM_DEPTH = 4096;
  localparam logic [ADDR_W:0] ERASE_END = 13'h1000;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] ERASE_READ_BYTE = 8'h00;
  localparam logic [7:0] LOCKED_READ_BYTE = 8'hFF;
  // Signature locations and bytes; byte values are arbitrary
  localparam logic [11:0] SIG_ADDR0 = 12'h000;
  localparam logic [11:0] SIG_ADDR1 = 12'h100;
  localparam logic [11:0] SIG_ADDR2 = 12'h200;
  localparam logic [7:0] SIG_BYTE0 = 8'h3C;
  localparam logic [7:0] SIG_BYTE1 = 8'h4D;
  localparam logic [7:0] SIG_BYTE2 = 8'h02;
  // Lock readback positions on the data lines
  localparam int LOCK1_POS = 2;
  localparam int LOCK2_POS = 3;
  localparam int LOCK3_POS = 4;
  // Parallel modes, bit order {ctl_a, ctl_b, ctl_c, signature_select_a, signature_select_b}
  localparam logic [4:0] MODE_WRITE_CODE = 5'h0F;
  localparam logic [4:0] MODE_READ_CODE = 5'h03;
  localparam logic [4:0] MODE_WRITE_LOCK1 = 5'h1F;
  localparam logic [4:0] MODE_WRITE_LOCK2 = 5'h1C;
  localparam logic [4:0] MODE_WRITE_LOCK3 = 5'h16;
  localparam logic [4:0] MODE_READ_LOCKS = 5'h1A;
  localparam logic [4:0] MODE_ERASE = 5'h14;
  localparam logic [4:0] MODE_READ_SIG = 5'h00;
  // Serial instruction bytes
  localparam logic [7:0] OP_SPECIAL = 8'hAC;
  localparam logic [7:0] OP_ENABLE = 8'h53;
  localparam logic [7:0] OP_ERASE = 8'h80;
  localparam logic [7:0] OP_READ = 8'h20;
  localparam logic [7:0] OP_WRITE = 8'h40;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [1:0] ADDR_LO_BYTE = 2'h2;
  // Register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_PAR = 0;
  localparam int CTRL_SER = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_ERASE = 2'b10
  } fpl_state_t;
endpackage

// ===== verilog/fpl_frame_if.sv
// Byte-level link between the serial shifter and the programming core
`timescale 1ns/100ps
`default_nettype none
interface fpl_frame_if;
  logic active;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [1:0] rx_index;
  logic [7:0] tx_byte;
  modport shifter (input active, input tx_byte, output rx_byte, output rx_valid,
    output rx_index);
  modport core (output active, output tx_byte, input rx_byte, input rx_valid,
    input rx_index);
endinterface
`default_nettype wire

// ===== verilog/fpl_serial_shift.sv
// Four-byte serial shift engine sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
module fpl_serial_shift (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  fpl_frame_if.shifter lnk
);
  import fpl_pkg::*;
  logic [1:0] s1, s2, s3, pin_q;
  logic sck_prev;
  logic [2:0] bit_cnt;
  logic [7:0] rx_sr;
  logic [6:0] tx_sr;
  logic rise, fall;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
      pin_q <= 2'h0;
      sck_prev <= 1'b0;
    end else begin
      s1 <= {sck, mosi};
      s2 <= s1;
      s3 <= s2;
      pin_q <= (s2 & s3) | (pin_q & (s2 ^ s3));
      sck_prev <= pin_q[1];
    end
  end

  assign rise = pin_q[1] & ~sck_prev;
  assign fall = ~pin_q[1] & sck_prev;

  // Receive: shift on rising edge, byte count wraps after four
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      rx_sr <= 8'h00;
      lnk.rx_valid <= 1'b0;
      lnk.rx_byte <= 8'h00;
      lnk.rx_index <= 2'h0;
    end else if (!lnk.active) begin
      bit_cnt <= 3'h0;
      lnk.rx_valid <= 1'b0;
      lnk.rx_index <= 2'h0;
    end else begin
      lnk.rx_valid <= 1'b0;
      if (rise) begin
        rx_sr <= {rx_sr[6:0], pin_q[0]};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          lnk.rx_byte <= {rx_sr[6:0], pin_q[0]};
          lnk.rx_valid <= 1'b1;
        end
      end
      if (lnk.rx_valid) begin
        lnk.rx_index <= lnk.rx_index + 2'h1;
      end
    end
  end

  // Transmit: MSB first, next byte loaded on the falling edge after a byte ends
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso <= 1'b0;
      tx_sr <= 7'h00;
    end else if (fall) begin
      if (bit_cnt == 3'h0) begin
        miso <= lnk.tx_byte[7];
        tx_sr <= lnk.tx_byte[6:0];
      end else begin
        miso <= tx_sr[6];
        tx_sr <= {tx_sr[5:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// ===== verilog/fpl_program_lock.sv
// Flash programming interface with three-level lock protection
// Function
// - Three lock bits; all unprogrammed means no protection.
// - First lock: block external table reads, latch access pin, refuse programming.
// - First and second lock: also refuse code verify reads.
// - All three locks: also block execution from external memory.
// - With first lock, access pin level is latched at reset.
// - Byte write is self-timed, about 50 us after the strobe.
// - During write, reading last byte inverts data line seven.
// - Polling reads may start any time after write start.
// - Ready/busy pin low after strobe rises, high when done.
// - Code readback only while the second lock is unprogrammed.
// - Each lock bit can be read back directly.
// - Signature bytes readable at three fixed addresses, selects low.
// - Serial erase instruction starts self-timed erase of about 500 ms.
// - Serial reads return zero while erase runs.
// - Serial mode only while reset pin high; clock, data in, data out.
// - Programming enable instruction must precede every other serial operation.
// - Erase sets every code byte to all ones.
// - Serial instructions are exactly four bytes.
// - Serial read of last byte during write inverts its MSB.
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fpl_program_lock #(
  parameter int WRITE_CYC = fpl_pkg::WRITE_CYCLES,
  parameter int ERASE_CYC = fpl_pkg::ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic reset_pin,
  input wire logic external_access_select_n,
  input wire logic program_voltage_high,
  input wire logic latch_and_program_strobe_n,
  input wire logic [4:0] mode_select,
  input wire logic [fpl_pkg::ADDR_W-1:0] prog_addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic ready_busy_pin,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic code_table_read_block,
  output logic external_exec_block,
  output logic access_select_level_n
);
  import fpl_pkg::*;
  localparam int PIN_W = 4 + 5 + ADDR_W + 8;

  logic [1:0] rst_sync;
  logic rst_n;
  logic [PIN_W-1:0] p1, p2, p3, pin_q;
  logic rst_pin_q, ea_q, vpp_q, strobe_q, strobe_prev;
  logic [4:0] mode_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] din_q;
  logic [7:0] mem [MEM_DEPTH];
  logic [2:0] lock;
  fpl_state_t state;
  logic [31:0] timer;
  logic [ADDR_W:0] erase_ptr;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] op_b1, op_b2, op_b3;
  logic prog_en;
  logic ea_latched;
  logic [2:0] cap_cnt;
  logic [1:0] ctrl;
  logic a_wr;
  logic [7:0] a_addr;
  logic par_active, ser_active, par_fire, ser_exec, idle;
  logic start_write, start_erase, write_done, erase_done;
  logic [ADDR_W-1:0] ser_addr;
  fpl_frame_if lnk ();

  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin inputs: three stages, change accepted when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p1 <= '0;
      p2 <= '0;
      p3 <= '0;
      pin_q <= '0;
      strobe_prev <= 1'b1;
    end else begin
      p1 <= {reset_pin, external_access_select_n, program_voltage_high,
        latch_and_program_strobe_n, mode_select, prog_addr, data_in};
      p2 <= p1;
      p3 <= p2;
      pin_q <= (p2 & p3) | (pin_q & (p2 ^ p3));
      strobe_prev <= strobe_q;
    end
  end
  assign {rst_pin_q, ea_q, vpp_q, strobe_q, mode_q, addr_q, din_q} = pin_q;

  // Mode qualification; both paths need the reset pin high
  assign par_active = ctrl[CTRL_PAR] & rst_pin_q;
  assign ser_active = ctrl[CTRL_SER] & rst_pin_q;
  assign lnk.active = ser_active;
  assign idle = (state == ST_IDLE);
  // Action taken when the strobe returns high with the 12 V enable present
  assign par_fire = par_active & vpp_q & strobe_q & ~strobe_prev & idle;
  assign ser_exec = ser_active & prog_en & lnk.rx_valid & (lnk.rx_index == LAST_BYTE);
  assign ser_addr = {op_b2[ADDR_W-9:0], op_b3};
  // Programming refused once the first lock is set
  assign start_write = ~lock[0] & ((par_fire & (mode_q == MODE_WRITE_CODE)) |
    (ser_exec & idle & (op_b1 == OP_WRITE)));
  assign start_erase = (par_fire & (mode_q == MODE_ERASE)) |
    (ser_exec & idle & (op_b1 == OP_SPECIAL) & (op_b2 == OP_ERASE));
  assign write_done = (state == ST_WRITE) & (timer == 32'h0);
  assign erase_done = (state == ST_ERASE) & (timer == 32'h0) & (erase_ptr == ERASE_END);

  // Code read path shared by verify and serial read
  function automatic logic [7:0] code_read(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = mem[a];
    if (lock[1]) begin
      v = LOCKED_READ_BYTE;
    end else if ((state == ST_WRITE) && (a == wr_addr)) begin
      v = {~wr_data[7], wr_data[6:0]};
    end
    return v;
  endfunction

  // Self-timed operation sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      timer <= 32'h0;
      wr_addr <= '0;
      wr_data <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_erase) begin
            state <= ST_ERASE;
            timer <= 32'(ERASE_CYC - 1);
          end else if (start_write) begin
            state <= ST_WRITE;
            timer <= 32'(WRITE_CYC - 1);
            wr_addr <= par_fire ? addr_q : ser_addr;
            wr_data <= par_fire ? din_q : lnk.rx_byte;
          end
        end
        ST_WRITE: begin
          if (write_done) begin
            state <= ST_IDLE;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        ST_ERASE: begin
          if (erase_done) begin
            state <= ST_IDLE;
          end else if (timer != 32'h0) begin
            timer <= timer - 32'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Erase sweep pointer, one location per cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_ptr <= '0;
    end else if (state != ST_ERASE) begin
      erase_ptr <= '0;
    end else if (erase_ptr != ERASE_END) begin
      erase_ptr <= erase_ptr + 13'h1;
    end
  end

  // Code array: writes can only clear bits, so reprogramming needs an erase first
  always_ff @(posedge clk) begin
    if ((state == ST_ERASE) && (erase_ptr != ERASE_END)) begin
      mem[erase_ptr[ADDR_W-1:0]] <= ERASED_BYTE;
    end else if (write_done) begin
      mem[wr_addr] <= mem[wr_addr] & wr_data;
    end
  end

  // Lock bits: set one at a time, cleared by reset or by a finished erase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock <= 3'h0;
    end else if (erase_done) begin
      lock <= 3'h0;
    end else if (par_fire) begin
      case (mode_q)
        MODE_WRITE_LOCK1: lock[0] <= 1'b1;
        MODE_WRITE_LOCK2: lock[1] <= 1'b1;
        MODE_WRITE_LOCK3: lock[2] <= 1'b1;
        default: lock <= lock;
      endcase
    end
  end

  // Access pin caught once the pin stages have filled after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt <= CAPTURE_DELAY;
      ea_latched <= 1'b0;
    end else if (cap_cnt != 3'h0) begin
      cap_cnt <= cap_cnt - 3'h1;
      if (cap_cnt == 3'h1) begin
        ea_latched <= ea_q;
      end
    end
  end

  // Protection outputs; latched level is only trusted if the system holds the pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_table_read_block <= 1'b0;
      external_exec_block <= 1'b0;
      access_select_level_n <= 1'b1;
    end else begin
      code_table_read_block <= lock[0];
      external_exec_block <= &lock;
      access_select_level_n <= lock[0] ? ea_latched : ea_q;
    end
  end

  // Busy pin falls after the strobe has risen and the write has started
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_busy_pin <= 1'b1;
    end else begin
      ready_busy_pin <= (state != ST_WRITE);
    end
  end

  // Parallel read port; not driven while the 12 V enable is present
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= 1'b1;
      data_out <= 8'h00;
      if (par_active && !vpp_q) begin
        case (mode_q)
          MODE_READ_CODE: begin
            data_oe_n <= 1'b0;
            data_out <= code_read(addr_q);
          end
          MODE_READ_LOCKS: begin
            data_oe_n <= 1'b0;
            data_out[LOCK1_POS] <= lock[0];
            data_out[LOCK2_POS] <= lock[1];
            data_out[LOCK3_POS] <= lock[2];
          end
          MODE_READ_SIG: begin
            data_oe_n <= 1'b0;
            case (addr_q)
              SIG_ADDR0: data_out <= SIG_BYTE0;
              SIG_ADDR1: data_out <= SIG_BYTE1;
              SIG_ADDR2: data_out <= SIG_BYTE2;
              default: data_out <= 8'h00;
            endcase
          end
          default: data_oe_n <= 1'b1;
        endcase
      end
    end
  end

  // Serial instruction capture and programming enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_b1 <= 8'h00;
      op_b2 <= 8'h00;
      op_b3 <= 8'h00;
      prog_en <= 1'b0;
    end else if (!ser_active) begin
      prog_en <= 1'b0;
    end else if (lnk.rx_valid) begin
      case (lnk.rx_index)
        2'h0: op_b1 <= lnk.rx_byte;
        2'h1: op_b2 <= lnk.rx_byte;
        ADDR_LO_BYTE: op_b3 <= lnk.rx_byte;
        default: begin
          if ((op_b1 == OP_SPECIAL) && (op_b2 == OP_ENABLE)) begin
            prog_en <= 1'b1;
          end
        end
      endcase
    end
  end

  // Serial read byte, prepared once the address is complete
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.tx_byte <= 8'h00;
    end else if (lnk.rx_valid && (lnk.rx_index == ADDR_LO_BYTE)) begin
      if (!prog_en || (op_b1 != OP_READ)) begin
        lnk.tx_byte <= 8'h00;
      end else if (state == ST_ERASE) begin
        lnk.tx_byte <= ERASE_READ_BYTE;
      end else begin
        lnk.tx_byte <= code_read({op_b2[ADDR_W-9:0], lnk.rx_byte});
      end
    end
  end

  // Shift clock is assumed below one sixteenth of clk for clean edge sampling
  fpl_serial_shift u_shift (
    .clk(clk),
    .rst_n(rst_n),
    .sck(sck),
    .mosi(mosi),
    .miso(miso),
    .lnk(lnk.shifter)
  );

  // Bus address phase capture; zero wait states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_wr <= 1'b0;
      a_addr <= 8'h00;
    end else if (hready) begin
      a_wr <= hsel & (htrans == HTRANS_NONSEQ) & hwrite;
      a_addr <= haddr[7:0];
    end
  end

  // Control register: enables for parallel and serial paths
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (a_wr && (a_addr == REG_CTRL)) begin
      ctrl <= hwdata[1:0];
    end
  end

  // Read data registered at the address phase; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready && hsel && (htrans == HTRANS_NONSEQ) && !hwrite) begin
        case (haddr[7:0])
          REG_CTRL: hrdata <= {30'h0, ctrl};
          REG_STATUS: hrdata <= {25'h0, ea_latched, prog_en, (state == ST_ERASE),
            (state == ST_WRITE), lock};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== sim/fpl_program_lock_assertions.sv
// Port-level property checker for the flash programming lock block
`timescale 1ns/100ps
`default_nettype none
module fpl_program_lock_assertions #(
  parameter int WRITE_CYC = fpl_pkg::WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic program_voltage_high,
  input wire logic latch_and_program_strobe_n,
  input wire logic data_oe_n,
  input wire logic ready_busy_pin,
  input wire logic sck,
  input wire logic miso,
  input wire logic code_table_read_block,
  input wire logic external_exec_block,
  input wire logic access_select_level_n
);
  logic [7:0] since_rise;
  logic [15:0] busy_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since the strobe rose, saturating so old strobes look far away
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      since_rise <= 8'hFF;
    end else if ($rose(latch_and_program_strobe_n)) begin
      since_rise <= 8'h00;
    end else if (since_rise != 8'hFF) begin
      since_rise <= since_rise + 8'h01;
    end
  end
  // Length of the current busy stretch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 16'h0000;
    end else if (ready_busy_pin) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= busy_cnt + 16'h0001;
    end
  end
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("bus response not OKAY");
  property p_ready_high;
    hreadyout == 1'b1;
  endproperty
  a_ready_high: assert property (p_ready_high) else $error("wait state inserted");
  property p_exec_needs_table;
    external_exec_block |-> code_table_read_block;
  endproperty
  a_exec_needs_table: assert property (p_exec_needs_table) else $error("exec block alone");
  property p_busy_after_strobe;
    $fell(ready_busy_pin) && program_voltage_high |-> since_rise < 8'd12;
  endproperty
  a_busy_after_strobe: assert property (p_busy_after_strobe) else $error("busy without strobe");
  property p_busy_length;
    $rose(ready_busy_pin) |-> busy_cnt >= WRITE_CYC - 2 && busy_cnt <= WRITE_CYC + 2;
  endproperty
  a_busy_length: assert property (p_busy_length) else $error("write time wrong");
  property p_locked_no_busy;
    code_table_read_block && ready_busy_pin |=> ready_busy_pin;
  endproperty
  a_locked_no_busy: assert property (p_locked_no_busy) else $error("locked write ran");
  property p_vpp_no_drive;
    program_voltage_high [*8] |-> data_oe_n;
  endproperty
  a_vpp_no_drive: assert property (p_vpp_no_drive) else $error("driving at 12 V");
  property p_miso_mode0;
    sck [*6] |-> $stable(miso);
  endproperty
  a_miso_mode0: assert property (p_miso_mode0) else $error("miso moved, clock high");
  property p_access_latched;
    code_table_read_block [*3] |-> $stable(access_select_level_n);
  endproperty
  a_access_latched: assert property (p_access_latched) else $error("latch followed pin");
endmodule
bind fpl_program_lock fpl_program_lock_assertions #(.WRITE_CYC(WRITE_CYC)) chk_inst (
  .clk, .rstn, .hreadyout, .hresp, .program_voltage_high, .latch_and_program_strobe_n,
  .data_oe_n, .ready_busy_pin, .sck, .miso, .code_table_read_block, .external_exec_block,
  .access_select_level_n);
`default_nettype wire

// ===== sim/fpl_isp_model.sv
// Programmer model driving the four-byte serial link
`timescale 1ns/100ps
`default_nettype none
module fpl_isp_model (
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // Clock rests low between frames
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  // One frame MSB first at 160 ns per bit; returns the last byte seen
  task automatic frame(input logic [31:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    #3;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #80;
      sck = 1'b1;
      if (i < 8) rx[i] = miso;
      #80;
      sck = 1'b0;
    end
    // Idle data line shows the inverse so a stale bit never passes
    mosi = ~tx[0];
  endtask
endmodule
`default_nettype wire

// ===== sim/flash_program_lock_interface_tb.sv
// Self-checking bench for the flash programming lock block
`timescale 1ns/100ps
`default_nettype none
module flash_program_lock_interface_tb;
  import fpl_pkg::*;
  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, reset_pin;
  logic external_access_select_n, program_voltage_high, latch_and_program_strobe_n;
  logic data_oe_n, ready_busy_pin, sck, mosi, miso;
  logic code_table_read_block, external_exec_block, access_select_level_n;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] mode_select;
  logic [11:0] prog_addr;
  logic [7:0] data_in, data_out, d;
  int bad_count = 0;
  int cmp_count = 0;
  assign hready = hreadyout;
  fpl_program_lock #(.WRITE_CYC(2000), .ERASE_CYC(10)) fpl_program_lock_inst (.clk, .rstn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .reset_pin, .external_access_select_n, .program_voltage_high, .latch_and_program_strobe_n,
    .mode_select, .prog_addr, .data_in, .data_out, .data_oe_n, .ready_busy_pin, .sck, .mosi,
    .miso, .code_table_read_block, .external_exec_block, .access_select_level_n);
  fpl_isp_model fpl_isp_model_inst (.sck, .mosi, .miso);
  // Free-running system clock
  always #4 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Single word transfer; the bench never assumes a wait-state count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Polls status until neither write nor erase is running
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      ahb(1'b0, REG_STATUS, 0);
      n++;
    end while (r[4:3] !== 2'h0 && n < 3000);
    chk(r[4:3], 2'h0);
  endtask
  // Strobed parallel operation with 12 V around a 320 ns strobe
  task automatic pulse(input logic [4:0] m, input logic [11:0] a, input logic [7:0] v);
    @(posedge clk);
    mode_select <= m;
    prog_addr <= a;
    data_in <= v;
    repeat (6) @(posedge clk);
    program_voltage_high <= 1'b1;
    repeat (10) @(posedge clk);
    latch_and_program_strobe_n <= 1'b0;
    repeat (40) @(posedge clk);
    latch_and_program_strobe_n <= 1'b1;
    repeat (12) @(posedge clk);
    program_voltage_high <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pread(input logic [4:0] m, input logic [11:0] a);
    @(posedge clk);
    mode_select <= m;
    prog_addr <= a;
    repeat (8) @(posedge clk);
    d = data_out;
  endtask
  task automatic t_regs();
    ahb(1'b0, REG_CTRL, 0);
    chk(r, CTRL_RESET);
    ahb(1'b0, REG_STATUS, 0);
    chk(r[5:0], 6'h00);
    chk(r[6], 1'b1);
    ahb(1'b1, 32'h8, 32'hFFFFFFFF);
    ahb(1'b0, 32'h8, 0);
    chk(r, 0);
    ahb(1'b1, REG_CTRL, 32'h1);
  endtask
  task automatic t_write();
    pulse(MODE_ERASE, 12'h000, 8'h00);
    wait_idle();
    pread(MODE_READ_CODE, 12'h123);
    chk(d, ERASED_BYTE);
    chk(data_oe_n, 1'b0);
    pulse(MODE_WRITE_CODE, 12'h123, 8'h5A);
    chk(ready_busy_pin, 1'b0);
    pread(MODE_READ_CODE, 12'h123);
    chk(d[7], 1'b1);
    wait_idle();
    chk(ready_busy_pin, 1'b1);
    pread(MODE_READ_CODE, 12'h123);
    chk(d, 8'h5A);
    // Read mode with the 12 V enable up must leave the data lines undriven
    pulse(MODE_READ_CODE, 12'h123, 8'h00);
    chk(data_oe_n, 1'b1);
    for (int i = 0; i < 3; i++) begin
      pread(MODE_READ_SIG, {i[3:0], 8'h00});
      chk(d, i == 0 ? SIG_BYTE0 : i == 1 ? SIG_BYTE1 : SIG_BYTE2);
    end
  endtask
  task automatic t_locks();
    pulse(MODE_WRITE_LOCK1, 12'h000, 8'h00);
    pread(MODE_READ_LOCKS, 12'h000);
    chk({d[LOCK3_POS], d[LOCK2_POS], d[LOCK1_POS]}, 3'h1);
    chk(code_table_read_block, 1'b1);
    external_access_select_n <= 1'b0;
    pulse(MODE_WRITE_CODE, 12'h124, 8'h00);
    chk(ready_busy_pin, 1'b1);
    chk(access_select_level_n, 1'b1);
    external_access_select_n <= 1'b1;
    pulse(MODE_WRITE_LOCK2, 12'h000, 8'h00);
    pread(MODE_READ_CODE, 12'h123);
    chk(d, LOCKED_READ_BYTE);
    chk(external_exec_block, 1'b0);
    pulse(MODE_WRITE_LOCK3, 12'h000, 8'h00);
    pread(MODE_READ_LOCKS, 12'h000);
    chk({d[LOCK3_POS], d[LOCK2_POS], d[LOCK1_POS]}, 3'h7);
    chk(external_exec_block, 1'b1);
  endtask
  task automatic t_serial();
    pulse(MODE_ERASE, 12'h000, 8'h00);
    wait_idle();
    chk(code_table_read_block, 1'b0);
    ahb(1'b1, REG_CTRL, 32'h2);
    fpl_isp_model_inst.frame({OP_WRITE, 24'h0A3477}, d);
    fpl_isp_model_inst.frame({OP_SPECIAL, OP_ENABLE, 16'h0000}, d);
    fpl_isp_model_inst.frame({OP_READ, 24'h0A3400}, d);
    chk(d, ERASED_BYTE);
    fpl_isp_model_inst.frame({OP_WRITE, 24'h0A3477}, d);
    fpl_isp_model_inst.frame({OP_READ, 24'h0A3400}, d);
    chk(d[7], 1'b1);
    wait_idle();
    fpl_isp_model_inst.frame({OP_READ, 24'h0A3400}, d);
    chk(d, 8'h77);
    fpl_isp_model_inst.frame({OP_SPECIAL, OP_ERASE, 16'h0000}, d);
    fpl_isp_model_inst.frame({OP_READ, 24'h0A3400}, d);
    chk(d, ERASE_READ_BYTE);
    wait_idle();
    fpl_isp_model_inst.frame({OP_READ, 24'h0A3400}, d);
    chk(d, ERASED_BYTE);
    ahb(1'b0, REG_STATUS, 0);
    chk(r[5], 1'b1);
    reset_pin <= 1'b0;
    repeat (8) @(posedge clk);
    ahb(1'b0, REG_STATUS, 0);
    chk(r[5], 1'b0);
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    {rstn, hsel, haddr, htrans, hwrite, hwdata, mode_select, prog_addr, data_in} = '0;
    {program_voltage_high, r, d} = '0;
    {reset_pin, external_access_select_n, latch_and_program_strobe_n} = '1;
    hsize = 3'h2;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_write();
    t_locks();
    t_serial();
    stop_test();
  end
  // Watchdog well past the expected run of about 21500 cycles
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
